/* File: include/ifd_pkg.sv */
// constants and types of the instruction format decoder
// assumes one 100 MHz clock and 18-bit words, bit 17 being word bit 0
package ifd_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W      = 18;
  localparam int OPC_MSB     = 17;
  localparam int OPC_LSB     = 14;
  localparam int OPC6_LSB    = 12;
  localparam int IND_BIT     = 13;
  localparam int IDX_BIT     = 12;
  localparam int PAGE_ADDR_W = 12;
  localparam int BANK_ADDR_W = 13;
  localparam int MICRO_W     = 14;
  localparam int MICRO6_W    = 12;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_MEMREF_LAST = 4'hc;
  localparam logic [3:0] OP_DEPOSIT_ACC = 4'h1;
  localparam logic [3:0] OP_EXT_ARITH   = 4'hd;
  localparam logic [3:0] OP_OPERATE     = 4'hf;
  localparam logic [5:0] OP6_IO_XFER    = 6'h38;
  localparam logic [5:0] OP6_INDEX      = 6'h3a;

  // ----------------------------------------------------------------
  // machine cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] CY_MEMREF   = 3'h2;
  localparam logic [2:0] CY_OPERATE  = 3'h1;
  localparam logic [2:0] CY_INDEX    = 3'h2;
  localparam logic [2:0] CY_IO_MIN   = 3'h2;
  localparam logic [2:0] CY_IO_MAX   = 3'h4;
  localparam logic [2:0] CY_EXT_MIN  = 3'h1;
  localparam logic [2:0] CY_EXT_MAX  = 3'h3;
  localparam logic [2:0] CY_INDIRECT = 3'h1;
  localparam logic [2:0] CY_AUTOINC  = 3'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MCYC_BASIC_NS   = 800;
  localparam int MCYC_PARITY_NS  = 1100;
  localparam int MCYC_CNT_W      = 7;
  // longest times, so rounded down
  localparam logic [MCYC_CNT_W-1:0] MCYC_BASIC_CLKS =
    MCYC_CNT_W'(MCYC_BASIC_NS / CLK_PERIOD_NS);
  localparam logic [MCYC_CNT_W-1:0] MCYC_PARITY_CLKS =
    MCYC_CNT_W'(MCYC_PARITY_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam int         REG_ADDR_W    = 4;
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_INDEX     = 4'h1;
  localparam logic [3:0] REG_STATUS    = 4'h2;
  localparam logic [3:0] REG_EFF_ADDR  = 4'h3;
  localparam logic [3:0] REG_DONE_CNT  = 4'h4;
  localparam int         CTRL_BANK_BIT = 0;
  localparam int         CTRL_PAR_BIT  = 1;
  localparam logic [1:0] CTRL_RST      = 2'h0;
  localparam logic [17:0] INDEX_RST    = 18'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IFD_GRP_MEMREF  = 3'h0,
    IFD_GRP_EXT     = 3'h1,
    IFD_GRP_IO      = 3'h2,
    IFD_GRP_INDEX   = 3'h3,
    IFD_GRP_OPERATE = 3'h4,
    IFD_GRP_BAD     = 3'h5
  } ifd_grp_t;

  typedef enum logic [2:0] {
    IFD_S_IDLE = 3'b000,
    IFD_S_INC  = 3'b001,
    IFD_S_IND  = 3'b011,
    IFD_S_OPND = 3'b010,
    IFD_S_EXEC = 3'b110,
    IFD_S_AUG  = 3'b100
  } ifd_state_t;

endpackage

/* File: core/ifd_mcycle_timer.sv */
// machine cycle timer: one tick at the end of each machine cycle
// assumes restart from the sequencer when an instruction is taken
`timescale 1ns/1ps
module ifd_mcycle_timer #(
  parameter logic [ifd_pkg::MCYC_CNT_W-1:0] BASIC_CLKS  =
    ifd_pkg::MCYC_BASIC_CLKS,
  parameter logic [ifd_pkg::MCYC_CNT_W-1:0] PARITY_CLKS =
    ifd_pkg::MCYC_PARITY_CLKS
) (
  // clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  // cycle control
  input  wire logic restart,
  input  wire logic parity_fitted,
  // cycle end
  output logic      tick
);

  logic [ifd_pkg::MCYC_CNT_W-1:0] cnt_q;
  logic [ifd_pkg::MCYC_CNT_W-1:0] len;

  assign len = parity_fitted ? PARITY_CLKS : BASIC_CLKS;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (en) begin
      if (restart) begin
        cnt_q <= '0;
        tick  <= 1'b0;
      end else if (cnt_q >= len - 1'b1) begin
        cnt_q <= '0;
        tick  <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tick  <= 1'b0;
      end
    end
  end

endmodule

/* File: core/ifd_decoder.sv */
// instruction format decoder and machine cycle sequencer
// assumes instruction words and memory read data on the same clock,
// memory answering within one machine cycle
`timescale 1ns/1ps
module ifd_decoder #(
  parameter int              EA_W       = 15,
  parameter logic [EA_W-1:0] AUTOINC_LO = EA_W'(8),
  parameter logic [EA_W-1:0] AUTOINC_HI = EA_W'(15),
  parameter int              CNT_W      = 16
) (
  // clock and control
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              en,
  // register port
  input  wire logic [ifd_pkg::REG_ADDR_W-1:0]    reg_addr,
  input  wire logic [ifd_pkg::WORD_W-1:0]        reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [ifd_pkg::WORD_W-1:0]        reg_rdata,
  // instruction in
  input  wire logic                              instr_valid,
  input  wire logic [ifd_pkg::WORD_W-1:0]        instr_word,
  output logic                                   instr_ready,
  // execution side
  input  wire logic [ifd_pkg::WORD_W-1:0]        main_working_register,
  input  wire logic                              aug_hold,
  input  wire logic                              arith_done,
  // memory bus
  input  wire logic [ifd_pkg::WORD_W-1:0]        mem_rdata,
  output logic                                   mem_rd,
  output logic                                   mem_wr,
  output logic      [EA_W-1:0]                   mem_addr,
  output logic      [ifd_pkg::WORD_W-1:0]        mem_wdata,
  // decode results
  output logic                                   is_memref,
  output logic                                   is_augmented,
  output logic                                   extended_arith_group,
  output logic                                   io_transfer_group,
  output logic                                   index_group,
  output logic                                   operate_group,
  output logic                                   illegal_group,
  output logic      [3:0]                        opcode,
  output logic                                   indirect,
  output logic                                   autoinc,
  output logic      [ifd_pkg::MICRO_W-1:0]       micro_code,
  output logic      [2:0]                        cycles_min,
  output logic      [2:0]                        cycles_max,
  output logic                                   var_time,
  output logic      [EA_W-1:0]                   eff_addr,
  output logic      [ifd_pkg::WORD_W-1:0]        operand,
  output logic                                   done
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic ifd_pkg::ifd_grp_t f_group(
    input logic [ifd_pkg::WORD_W-1:0] w);
    logic [3:0] op4;
    logic [5:0] op6;
    op4 = w[ifd_pkg::OPC_MSB:ifd_pkg::OPC_LSB];
    op6 = w[ifd_pkg::OPC_MSB:ifd_pkg::OPC6_LSB];
    if (op4 <= ifd_pkg::OP_MEMREF_LAST)
      return ifd_pkg::IFD_GRP_MEMREF;
    else if (op4 == ifd_pkg::OP_EXT_ARITH)
      return ifd_pkg::IFD_GRP_EXT;
    else if (op4 == ifd_pkg::OP_OPERATE)
      return ifd_pkg::IFD_GRP_OPERATE;
    else if (op6 == ifd_pkg::OP6_IO_XFER)
      return ifd_pkg::IFD_GRP_IO;
    else if (op6 == ifd_pkg::OP6_INDEX)
      return ifd_pkg::IFD_GRP_INDEX;
    else
      return ifd_pkg::IFD_GRP_BAD;
  endfunction

  // base cycles as {min, max}
  function automatic logic [5:0] f_cycles(input ifd_pkg::ifd_grp_t g);
    unique case (g)
      ifd_pkg::IFD_GRP_MEMREF:
        return {ifd_pkg::CY_MEMREF, ifd_pkg::CY_MEMREF};
      ifd_pkg::IFD_GRP_EXT:
        return {ifd_pkg::CY_EXT_MIN, ifd_pkg::CY_EXT_MAX};
      ifd_pkg::IFD_GRP_IO:
        return {ifd_pkg::CY_IO_MIN, ifd_pkg::CY_IO_MAX};
      ifd_pkg::IFD_GRP_INDEX:
        return {ifd_pkg::CY_INDEX, ifd_pkg::CY_INDEX};
      ifd_pkg::IFD_GRP_OPERATE:
        return {ifd_pkg::CY_OPERATE, ifd_pkg::CY_OPERATE};
      default:
        return {ifd_pkg::CY_OPERATE, ifd_pkg::CY_OPERATE};
    endcase
  endfunction

  function automatic logic [EA_W-1:0] f_opnd_addr(
    input logic [ifd_pkg::WORD_W-1:0] w,
    input logic                       bank);
    logic [EA_W-1:0] a;
    a = '0;
    if (bank)
      a[ifd_pkg::BANK_ADDR_W-1:0] = w[ifd_pkg::BANK_ADDR_W-1:0];
    else
      a[ifd_pkg::PAGE_ADDR_W-1:0] = w[ifd_pkg::PAGE_ADDR_W-1:0];
    return a;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ifd_pkg::ifd_state_t             state_q, state_d;
  ifd_pkg::ifd_grp_t               grp_q, grp_d, cap_grp;
  logic [1:0]                      ctrl_q;
  logic [ifd_pkg::WORD_W-1:0]      index_q;
  logic [EA_W-1:0]                 ea_q, ea_d, cap_ea;
  logic [ifd_pkg::WORD_W-1:0]      ptr_q, ptr_d;
  logic [3:0]                      opc_d;
  logic                            ind_d, auto_d, cap_ind, cap_auto;
  logic [2:0]                      aug_cnt_q, aug_cnt_d;
  logic [2:0]                      cap_min, cap_max;
  logic [CNT_W-1:0]                done_cnt_q;
  logic                            take, tick, fin;

  assign take = instr_ready && instr_valid &&
                (state_q == ifd_pkg::IFD_S_IDLE);

  // ----------------------------------------------------------------
  // machine cycle timer
  // ----------------------------------------------------------------
  ifd_mcycle_timer u_timer (
    .clk           (clk),
    .rst           (rst),
    .en            (en),
    .restart       (take),
    .parity_fitted (ctrl_q[ifd_pkg::CTRL_PAR_BIT]),
    .tick          (tick)
  );

  // ----------------------------------------------------------------
  // decode of the incoming word
  // ----------------------------------------------------------------
  always_comb begin
    logic [EA_W-1:0] base;
    logic            bank;
    bank     = ctrl_q[ifd_pkg::CTRL_BANK_BIT];
    base     = f_opnd_addr(instr_word, bank);
    cap_grp  = f_group(instr_word);
    cap_ind  = (cap_grp == ifd_pkg::IFD_GRP_MEMREF) &&
               instr_word[ifd_pkg::IND_BIT];
    cap_ea   = base;
    if (!bank && instr_word[ifd_pkg::IDX_BIT])
      cap_ea = base + index_q[EA_W-1:0];
    cap_auto = cap_ind && (cap_ea >= AUTOINC_LO) &&
               (cap_ea <= AUTOINC_HI);
    {cap_min, cap_max} = f_cycles(cap_grp);
    if (cap_auto) begin
      cap_min = cap_min + ifd_pkg::CY_AUTOINC;
      cap_max = cap_max + ifd_pkg::CY_AUTOINC;
    end else if (cap_ind) begin
      cap_min = cap_min + ifd_pkg::CY_INDIRECT;
      cap_max = cap_max + ifd_pkg::CY_INDIRECT;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] next_cnt;
    next_cnt  = aug_cnt_q + 3'h1;
    state_d   = state_q;
    grp_d     = take ? cap_grp : grp_q;
    opc_d     = take ? instr_word[ifd_pkg::OPC_MSB:ifd_pkg::OPC_LSB]
                     : opcode;
    ind_d     = take ? cap_ind : indirect;
    auto_d    = take ? cap_auto : autoinc;
    ea_d      = take ? cap_ea : ea_q;
    ptr_d     = ptr_q;
    aug_cnt_d = take ? 3'h0 : aug_cnt_q;
    fin       = 1'b0;
    unique case (state_q)
      ifd_pkg::IFD_S_IDLE: begin
        if (take) begin
          if (cap_grp != ifd_pkg::IFD_GRP_MEMREF)
            state_d = ifd_pkg::IFD_S_AUG;
          else if (cap_auto)
            state_d = ifd_pkg::IFD_S_INC;
          else if (cap_ind)
            state_d = ifd_pkg::IFD_S_IND;
          else
            state_d = ifd_pkg::IFD_S_OPND;
        end
      end
      ifd_pkg::IFD_S_INC: begin
        if (tick) begin
          ptr_d   = mem_rdata + 18'h1;
          state_d = ifd_pkg::IFD_S_IND;
        end
      end
      ifd_pkg::IFD_S_IND: begin
        if (tick) begin
          // pointer is the final address, never followed again
          ea_d    = autoinc ? ptr_q[EA_W-1:0]
                            : mem_rdata[EA_W-1:0];
          state_d = ifd_pkg::IFD_S_OPND;
        end
      end
      ifd_pkg::IFD_S_OPND: begin
        if (tick)
          state_d = ifd_pkg::IFD_S_EXEC;
      end
      ifd_pkg::IFD_S_EXEC: begin
        if (tick) begin
          fin     = 1'b1;
          state_d = ifd_pkg::IFD_S_IDLE;
        end
      end
      ifd_pkg::IFD_S_AUG: begin
        if (tick) begin
          aug_cnt_d = next_cnt;
          // finish at cycles_min, or at cycles_max while aug_hold is high, and not before arith_done when var_time
          if (next_cnt >= cycles_min &&
              (!aug_hold || next_cnt >= cycles_max) &&
              (!var_time || arith_done)) begin
            fin     = 1'b1;
            state_d = ifd_pkg::IFD_S_IDLE;
          end
        end
      end
      default: state_d = ifd_pkg::IFD_S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= ifd_pkg::IFD_S_IDLE;
      grp_q     <= ifd_pkg::IFD_GRP_MEMREF;
      ea_q      <= '0;
      ptr_q     <= '0;
      aug_cnt_q <= '0;
    end else if (en) begin
      state_q   <= state_d;
      grp_q     <= grp_d;
      ea_q      <= ea_d;
      ptr_q     <= ptr_d;
      aug_cnt_q <= aug_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // decode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      is_memref            <= 1'b0;
      is_augmented         <= 1'b0;
      extended_arith_group <= 1'b0;
      io_transfer_group    <= 1'b0;
      index_group          <= 1'b0;
      operate_group        <= 1'b0;
      illegal_group        <= 1'b0;
      opcode               <= 4'h0;
      indirect             <= 1'b0;
      autoinc              <= 1'b0;
      micro_code           <= '0;
      cycles_min           <= 3'h0;
      cycles_max           <= 3'h0;
      var_time             <= 1'b0;
    end else if (en && take) begin
      is_memref            <= cap_grp == ifd_pkg::IFD_GRP_MEMREF;
      is_augmented         <= cap_grp != ifd_pkg::IFD_GRP_MEMREF;
      extended_arith_group <= cap_grp == ifd_pkg::IFD_GRP_EXT;
      io_transfer_group    <= cap_grp == ifd_pkg::IFD_GRP_IO;
      index_group          <= cap_grp == ifd_pkg::IFD_GRP_INDEX;
      operate_group        <= cap_grp == ifd_pkg::IFD_GRP_OPERATE;
      illegal_group        <= cap_grp == ifd_pkg::IFD_GRP_BAD;
      opcode               <= opc_d;
      indirect             <= cap_ind;
      autoinc              <= cap_auto;
      // six-bit groups carry fewer code bits
      if (cap_grp == ifd_pkg::IFD_GRP_IO ||
          cap_grp == ifd_pkg::IFD_GRP_INDEX)
        micro_code <= {2'h0, instr_word[ifd_pkg::MICRO6_W-1:0]};
      else
        micro_code <= instr_word[ifd_pkg::MICRO_W-1:0];
      cycles_min           <= cap_min;
      cycles_max           <= cap_max;
      var_time             <= cap_grp == ifd_pkg::IFD_GRP_EXT;
    end
  end

  // ----------------------------------------------------------------
  // memory bus and results
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      mem_addr    <= '0;
      mem_wdata   <= '0;
      eff_addr    <= '0;
      operand     <= '0;
      done        <= 1'b0;
      instr_ready <= 1'b0;
      done_cnt_q  <= '0;
    end else if (en) begin
      mem_rd <= (state_d == ifd_pkg::IFD_S_INC) ||
                (state_d == ifd_pkg::IFD_S_IND && !auto_d) ||
                (state_d == ifd_pkg::IFD_S_OPND &&
                 opc_d != ifd_pkg::OP_DEPOSIT_ACC);
      mem_wr <= (state_d == ifd_pkg::IFD_S_IND && auto_d) ||
                (state_d == ifd_pkg::IFD_S_OPND &&
                 opc_d == ifd_pkg::OP_DEPOSIT_ACC);
      mem_addr  <= ea_d;
      // deposit stores the accumulator, which stays unchanged
      mem_wdata <= (state_d == ifd_pkg::IFD_S_OPND) ?
                   main_working_register : ptr_d;
      eff_addr  <= ea_d;
      if (state_q == ifd_pkg::IFD_S_OPND && tick && mem_rd)
        operand <= mem_rdata;
      done        <= fin;
      instr_ready <= state_d == ifd_pkg::IFD_S_IDLE;
      if (fin)
        done_cnt_q <= done_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q  <= ifd_pkg::CTRL_RST;
      index_q <= ifd_pkg::INDEX_RST;
    end else if (en && reg_wr) begin
      if (reg_addr == ifd_pkg::REG_CTRL)
        ctrl_q <= reg_wdata[1:0];
      if (reg_addr == ifd_pkg::REG_INDEX)
        index_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          ifd_pkg::REG_CTRL:     reg_rdata <= {16'h0, ctrl_q};
          ifd_pkg::REG_INDEX:    reg_rdata <= index_q;
          ifd_pkg::REG_STATUS:
            reg_rdata <= {8'h0, !instr_ready, indirect, autoinc,
                          grp_q, opcode};
          ifd_pkg::REG_EFF_ADDR:
            reg_rdata <= ifd_pkg::WORD_W'(ea_q);
          ifd_pkg::REG_DONE_CNT:
            reg_rdata <= ifd_pkg::WORD_W'(done_cnt_q);
          default:               reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule

/* File: verification/ifd_sva.sv */
// checker on the decoder ports
// assumes one clock and en high around each take
`timescale 1ns/1ps
module ifd_sva (
  // watched ports
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        en,
  input wire logic        instr_valid,
  input wire logic [17:0] instr_word,
  input wire logic        instr_ready,
  input wire logic        mem_rd,
  input wire logic        is_memref,
  input wire logic        is_augmented,
  input wire logic        extended_arith_group,
  input wire logic        io_transfer_group,
  input wire logic        index_group,
  input wire logic        operate_group,
  input wire logic [3:0]  opcode,
  input wire logic        indirect,
  input wire logic        autoinc,
  input wire logic [2:0]  cycles_min,
  input wire logic [2:0]  cycles_max,
  input wire logic [13:0] micro_code,
  input wire logic        var_time,
  input wire logic        done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       tk  = en && instr_valid && instr_ready;
  wire [5:0] w6  = instr_word[17:12];
  wire [3:0] op4 = instr_word[17:14];
  property p_class;
    tk |=> is_augmented == ($past(w6) > 6'h33) && is_memref != is_augmented;
  endproperty
  a_class: assert property (p_class) else $error("class wrong");
  property p_opc;
    tk |=> opcode == $past(op4);
  endproperty
  a_opc: assert property (p_opc) else $error("opcode wrong");
  property p_grp4;
    tk |=> extended_arith_group == ($past(op4) == 4'hd)
      && operate_group == ($past(op4) == 4'hf);
  endproperty
  a_grp4: assert property (p_grp4) else $error("four-bit group");
  property p_grp6;
    tk |=> io_transfer_group == ($past(w6) == 6'h38)
      && index_group == ($past(w6) == 6'h3a);
  endproperty
  a_grp6: assert property (p_grp6) else $error("six-bit group");
  property p_ind;
    tk && op4 <= 4'hc |=> indirect == $past(w6[1]);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect flag");
  property p_opcyc;
    tk && op4 == 4'hf |=> cycles_min == 3'h1 ##[70:90] done;
  endproperty
  a_opcyc: assert property (p_opcyc) else $error("operate time");
  property p_indcyc;
    is_memref && indirect && !autoinc |-> cycles_min == 3'h3;
  endproperty
  a_indcyc: assert property (p_indcyc) else $error("indirect time");
  property p_aicyc;
    is_memref && autoinc |-> indirect && cycles_min == 3'h4;
  endproperty
  a_aicyc: assert property (p_aicyc) else $error("autoinc time");
  property p_dep;
    is_memref && opcode == 4'h1 && !indirect |-> !mem_rd;
  endproperty
  a_dep: assert property (p_dep) else $error("deposit read");
  property p_micro;
    tk |=> micro_code == ((($past(w6) & 6'h3d) == 6'h38) ?
      {2'h0, $past(instr_word[11:0])} : $past(instr_word[13:0]));
  endproperty
  a_micro: assert property (p_micro) else $error("micro code");
  property p_arcyc;
    tk && op4 == 4'hd |=> var_time && cycles_min == 3'h1
      && cycles_max == 3'h3;
  endproperty
  a_arcyc: assert property (p_arcyc) else $error("arithmetic time");
  property p_iocyc;
    tk && w6 == 6'h38 |=> !var_time && cycles_min == 3'h2
      && cycles_max == 3'h4;
  endproperty
  a_iocyc: assert property (p_iocyc) else $error("transfer time");
endmodule

bind ifd_decoder ifd_sva u_ifd_sva (.*);

/* File: verification/ifd_mem_model.sv */
// core memory partner: stores writes, answers reads late
// assumes reads held for a whole machine cycle
`timescale 1ns/1ps
module ifd_mem_model #(
  parameter int LAT = 3
) (
  // memory bus
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [14:0] mem_addr,
  input  wire logic [17:0] mem_wdata,
  output logic      [17:0] mem_rdata
);
  logic [17:0] mem [0:32767];
  logic [17:0] last_q = 18'h0;
  int          wait_q = 0;
  // released bus shows the inverse of the last word
  always @(posedge clk) begin
    wait_q <= mem_rd ? wait_q + 1 : 0;
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    if (mem_rd && wait_q >= LAT) begin
      mem_rdata <= mem[mem_addr];
      last_q    <= mem[mem_addr];
    end else
      mem_rdata <= ~last_q;
  end
endmodule

/* File: verification/test_ifd_decoder.sv */
// bench of the instruction format decoder
// assumes the memory model behind the memory bus
`timescale 1ns/1ps
module test_ifd_decoder;
  logic        clk, rst, en, reg_wr, reg_rd, instr_valid, instr_ready;
  logic        aug_hold, arith_done, mem_rd, mem_wr, is_memref, is_augmented;
  logic        extended_arith_group, io_transfer_group, index_group;
  logic        operate_group, illegal_group, indirect, autoinc, var_time;
  logic        done;
  logic [3:0]  reg_addr, opcode;
  logic [2:0]  cycles_min, cycles_max;
  logic [13:0] micro_code;
  logic [14:0] mem_addr, eff_addr;
  logic [17:0] reg_wdata, reg_rdata, instr_word, main_working_register;
  logic [17:0] mem_rdata, mem_wdata, operand;
  logic [49:0] q[$];
  logic [49:0] e, g;
  logic [31:0] r;
  time         t0;
  int          bad_count, cmp_count, i;
  int          cy_ns = 800;
  integer      seed;
  localparam logic [5:0] TOP [5] = '{6'h3c, 6'h34, 6'h38, 6'h3a, 6'h39};
  localparam logic [2:0] CYF [5] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h1};
  localparam logic [2:0] CYH [5] = '{3'h1, 3'h3, 3'h4, 3'h2, 3'h1};

  ifd_decoder   u_ifd_decoder (.*);
  ifd_mem_model u_ifd_mem_model (.*);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] gv, ev, input string nm);
    cmp_count++;
    if (gv !== ev) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ev, gv);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [17:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [17:0] d);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, d, "reg_rdata");
  endtask
  task automatic run(input logic [17:0] w, input logic bk, input logic [2:0] b);
    logic [3:0]  o;
    logic        m, ind, ai, x;
    logic [14:0] pa, ea;
    int          k;
    o = w[17:14];
    m = o <= 4'hc;
    ind = m & w[13];
    pa = bk ? {2'h0, w[12:0]} : {3'h0, w[11:0]} + (w[12] ? 15'h5 : 15'h0);
    ai = ind && pa >= 15'h8 && pa <= 15'hf;
    ea = ind ? 15'(u_ifd_mem_model.mem[pa] + 18'(ai)) : pa;
    x = m && o != 4'h1;
    @(posedge clk);
    {instr_valid, instr_word} <= {1'b1, w};
    main_working_register <= 18'($random(seed));
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (instr_ready !== 1'b1 && k < 9);
    chk(instr_ready, 1'b1, "instr_ready");
    q.push_back({m, !m, o == 4'hd, w[17:12] == 6'h38, w[17:12] == 6'h3a,
      o == 4'hf, o == 4'he && w[12], o, ind, ai, m ? ea : 15'h0,
      m ? 3'h2 + 3'(ind) + 3'(ai) : b, x ? u_ifd_mem_model.mem[ea] : 18'h0, x});
    t0 = $time;
    instr_valid <= 1'b0;
    for (k = 0; k < 600 && done !== 1'b1; k++)
      @(posedge clk);
    chk(done, 1'b1, "done");
    if (m && o == 4'h1)
      chk(u_ifd_mem_model.mem[ea], main_working_register, "deposit");
  endtask
  task automatic report_and_stop;
    chk(q.size(), 0, "queue");
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, monitor, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (done === 1'b1) begin
      e = q.pop_front();
      g = {is_memref, is_augmented, extended_arith_group, io_transfer_group,
        index_group, operate_group, illegal_group, opcode,
        indirect & is_memref, autoinc & is_memref,
        is_memref ? eff_addr : 15'h0, 3'(($time - t0) / cy_ns),
        e[0] ? operand : 18'h0, e[0]};
      chk(g, e, "result");
    end
  end
  initial begin
    #400000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    seed = 32'ha793;
    {rst, en, arith_done, reg_wr, reg_rd, instr_valid, aug_hold} = 7'h70;
    {reg_addr, reg_wdata, instr_word, main_working_register} = 58'h0;
    for (i = 0; i < 32768; i++)
      u_ifd_mem_model.mem[i] = 18'(i * 7 + 3);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h0, 18'h0);
    rd_chk(4'h1, 18'h0);
    rd_chk(4'h7, 18'h0);
    wr(4'h1, 18'h5);
    rd_chk(4'h1, 18'h5);
    $display("registers finished");
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      run({4'(r[3:0] % 4'hd), r[4], r[11] ? 1'b0 : r[5],
        r[11] ? r[23:12] : 12'(r[16:12])}, 1'b0, 3'h0);
    end
    $display("page mode finished");
    wr(4'h0, 18'h1);
    rd_chk(4'h0, 18'h1);
    run(18'h09fff, 1'b1, 3'h0);
    rd_chk(4'h3, 18'h01fff);
    rd_chk(4'h2, 18'h00002);
    for (i = 0; i < 10; i++) begin
      r = $random(seed);
      run({4'(r[3:0] % 4'hd), r[4], r[17:5]}, 1'b1, 3'h0);
    end
    $display("bank mode finished");
    for (i = 0; i < 10; i++) begin
      r = $random(seed);
      aug_hold <= i >= 5;
      run({TOP[i % 5] | (i % 5 < 2 ? {4'h0, r[13:12]} : 6'h0), r[11:0]},
        1'b0, i >= 5 ? CYH[i % 5] : CYF[i % 5]);
    end
    $display("augmented finished");
    wr(4'h0, 18'h2);
    cy_ns = 1100;
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      run({4'(r[3:0] % 4'hd), r[5:4], 12'(r[16:12])}, 1'b0, 3'h0);
    end
    rd_chk(4'h4, 18'h41);
    $display("parity mode finished");
    report_and_stop;
  end
endmodule
